// >>> hdl/ccr_regs.sv
// register bank of the level-2 cache controller behind two slave ports
`timescale 1ns/1ps
module ccr_regs
  import ccr_pkg::*;
#(
  parameter logic [7:0] ID_IMPLEMENTOR = 8'h5a, // arbitrary value
  parameter logic [3:0] ID_PART        = 4'h1,
  parameter logic [5:0] ID_RELEASE     = 6'h0f
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        rw_port_reg_select,
  input  wire logic [1:0]  rw_htrans,
  input  wire logic        rw_hwrite,
  input  wire logic [2:0]  rw_hsize,
  input  wire logic [11:0] rw_slave_port_address,
  input  wire logic [63:0] rw_hwdata,
  input  wire logic        rw_hready,
  output logic             rw_hreadyout,
  output logic [1:0]       rw_hresp,
  output logic [63:0]      rw_hrdata,
  input  wire logic        wo_port_reg_select,
  input  wire logic [1:0]  wo_htrans,
  input  wire logic        wo_hwrite,
  input  wire logic [2:0]  wo_hsize,
  input  wire logic [11:0] wo_slave_port_address,
  input  wire logic [63:0] wo_hwdata,
  input  wire logic        wo_hready,
  output logic             wo_hreadyout,
  output logic [1:0]       wo_hresp,
  input  wire logic        write_port_steer,
  input  wire logic [5:0]  layout_identifier_pins,
  input  wire logic        rw_txn_start,
  input  wire logic        wo_txn_start,
  output logic             rw_cache_enable_q,
  output logic             wo_cache_enable_q,
  output logic [31:0]      ext_control_q,
  output logic [31:0]      data_way_lock_q,
  output logic [31:0]      instr_way_lock_q,
  output logic             maint_valid_q,
  output logic [11:0]      maint_offset_q,
  output logic [31:0]      maint_data_q
);

  // port capture
  logic        rw_start;
  logic        rw_act_q;
  logic        rw_write_q;
  logic [11:0] rw_addr_q;
  logic        rw_size_q;
  logic        wo_act_q;
  logic        wo_write_q;
  logic [11:0] wo_addr_q;
  logic        wo_size_q;

  ccr_port_capture u_rw_cap (
    .clock   (clock),
    .rst_n   (rst_n),
    .select  (rw_port_reg_select),
    .allow   (1'b1),
    .htrans  (rw_htrans),
    .hwrite  (rw_hwrite),
    .hsize   (rw_hsize),
    .haddr   (rw_slave_port_address),
    .hready  (rw_hready),
    .start   (rw_start),
    .act_q   (rw_act_q),
    .write_q (rw_write_q),
    .addr_q  (rw_addr_q)
  );

  ccr_port_capture u_wo_cap (
    .clock   (clock),
    .rst_n   (rst_n),
    .select  (wo_port_reg_select),
    .allow   (write_port_steer),
    .htrans  (wo_htrans),
    .hwrite  (wo_hwrite),
    .hsize   (wo_hsize),
    .haddr   (wo_slave_port_address),
    .hready  (wo_hready),
    .start   (),
    .act_q   (wo_act_q),
    .write_q (wo_write_q),
    .addr_q  (wo_addr_q)
  );

  // doubleword flag per data phase
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rw_size_q <= 1'b0;
      wo_size_q <= 1'b0;
    end else begin
      if (rw_hready) begin
        rw_size_q <= (rw_hsize == HSIZE_DWORD);
      end
      if (wo_hready) begin
        wo_size_q <= (wo_hsize == HSIZE_DWORD);
      end
    end
  end

  // steer sampled with the address phase so a late change splits no beat
  logic rw_steer_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rw_steer_q <= 1'b0;
    end else if (rw_hready) begin
      rw_steer_q <= write_port_steer;
    end
  end

  // zero wait states, always okay
  assign rw_hreadyout = 1'b1;
  assign wo_hreadyout = 1'b1;
  assign rw_hresp     = HRESP_OKAY;
  assign wo_hresp     = HRESP_OKAY;

  // merged write; steer lets only one port write, read-write port wins a clash
  logic        rw_wr;
  logic        wo_wr;
  logic        wr_en;
  logic [11:0] wr_addr;
  logic [63:0] wr_bus;
  logic        wr_dword;
  logic [31:0] wr_word;

  assign rw_wr    = rw_act_q && rw_write_q && !rw_steer_q;
  assign wo_wr    = wo_act_q && wo_write_q;
  assign wr_en    = rw_wr || wo_wr;
  assign wr_addr  = rw_wr ? rw_addr_q : wo_addr_q;
  assign wr_bus   = rw_wr ? rw_hwdata : wo_hwdata;
  assign wr_dword = rw_wr ? rw_size_q : wo_size_q;
  assign wr_word  = wr_addr[2] ? wr_bus[63:32] : wr_bus[31:0];

  function automatic logic hit(input logic [11:0] off);
    hit = wr_en && (wr_addr == off);
  endfunction : hit

  // layout identifier pins are tied off-chip, so synchronise them
  logic [5:0] pins_meta_q;
  logic [5:0] pins_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pins_meta_q <= 6'h00;
      pins_q      <= 6'h00;
    end else begin
      pins_meta_q <= layout_identifier_pins;
      pins_q      <= pins_meta_q;
    end
  end

  // stored registers
  logic [31:0] main_ctrl_q;
  logic [31:0] inv_ways_q;
  logic [31:0] cln_ways_q;
  logic [31:0] fls_ways_q;
  logic [31:0] line_tag_q;
  logic [31:0] dbg_ctrl_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      main_ctrl_q   <= RST_MAIN_CTRL;
      ext_control_q <= RST_EXT_CTRL;
    end else begin
      if (hit(OFF_MAIN_CTRL)) begin
        main_ctrl_q <= wr_word & MASK_MAIN_CTRL;
      end
      if (hit(OFF_EXT_CTRL)) begin
        ext_control_q <= wr_word & MASK_EXT_CTRL;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      inv_ways_q <= RST_ZERO;
      cln_ways_q <= RST_ZERO;
      fls_ways_q <= RST_ZERO;
    end else begin
      if (hit(OFF_INV_WAYS)) begin
        inv_ways_q <= wr_word;
      end
      if (hit(OFF_CLN_WAYS)) begin
        cln_ways_q <= wr_word;
      end
      if (hit(OFF_FLS_WAYS)) begin
        fls_ways_q <= wr_word;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_way_lock_q  <= RST_ZERO;
      instr_way_lock_q <= RST_ZERO;
    end else begin
      if (hit(OFF_DATA_LOCK)) begin
        data_way_lock_q <= wr_word;
      end
      if (hit(OFF_INSTR_LOCK)) begin
        instr_way_lock_q <= wr_word;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      line_tag_q <= RST_ZERO;
      dbg_ctrl_q <= RST_ZERO;
    end else begin
      if (hit(OFF_LINE_TAG)) begin
        line_tag_q <= wr_word;
      end
      if (hit(OFF_DBG_CTRL)) begin
        dbg_ctrl_q <= wr_word;
      end
    end
  end

  // maintenance and test writes go out as a one-cycle command
  logic maint_hit;
  assign maint_hit = hit(OFF_SYNC_OP) || hit(OFF_INV_PHYS) || hit(OFF_INV_WAYS)
                   || hit(OFF_CLN_PHYS) || hit(OFF_CLN_SETWAY) || hit(OFF_CLN_WAYS)
                   || hit(OFF_FLS_PHYS) || hit(OFF_FLS_SETWAY) || hit(OFF_FLS_WAYS)
                   || hit(OFF_TEST_OP);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      maint_valid_q  <= 1'b0;
      maint_offset_q <= 12'h000;
      maint_data_q   <= RST_ZERO;
    end else begin
      maint_valid_q <= maint_hit;
      if (maint_hit) begin
        maint_offset_q <= wr_addr;
        maint_data_q   <= wr_word;
      end
    end
  end

  // enable seen per port only when that port opens a transaction
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rw_cache_enable_q <= 1'b0;
      wo_cache_enable_q <= 1'b0;
    end else begin
      if (rw_txn_start) begin
        rw_cache_enable_q <= main_ctrl_q[POS_ENABLE];
      end
      if (wo_txn_start) begin
        wo_cache_enable_q <= main_ctrl_q[POS_ENABLE];
      end
    end
  end

  // line data store, word or doubleword lanes
  logic [1:0]  line_lane;
  logic [1:0]  line_wr_idx;
  logic [1:0]  line_rd_idx;
  logic [63:0] line_rd_q;
  logic [11:0] rw_addr_now;

  assign rw_addr_now = rw_slave_port_address;
  assign line_wr_idx = wr_addr[4:3] - OFF_LINE_FIRST[4:3];
  assign line_rd_idx = rw_addr_now[4:3] - OFF_LINE_FIRST[4:3];
  assign line_lane   = !(wr_en && is_line(wr_addr)) ? 2'h0 :
                       wr_dword ? 2'h3 :
                       wr_addr[2] ? 2'h2 : 2'h1;

  ccr_line_mem #(
    .WORD  (32),
    .DEPTH (4)
  ) u_line_mem (
    .clock     (clock),
    .rst_n     (rst_n),
    .wr_index  (line_wr_idx),
    .wr_lane   (line_lane),
    .wr_data   (wr_bus),
    .rd_index  (line_rd_idx),
    .rd_data_q (line_rd_q)
  );

  // read mux; write-only, sync and test words read as zero
  logic [31:0] ident;
  logic [31:0] rd_word;

  always_comb begin
    ident = 32'h0000_0000;
    ident[POS_ID_IMPL +: 8] = ID_IMPLEMENTOR;
    ident[POS_ID_PINS +: 6] = pins_q;
    ident[POS_ID_PART +: 4] = ID_PART;
    ident[POS_ID_REL  +: 6] = ID_RELEASE;
  end

  always_comb begin
    case ({rw_addr_now[11:2], 2'h0})
      OFF_IDENT:      rd_word = ident;
      OFF_GEOMETRY:   rd_word = geometry(ext_control_q);
      OFF_MAIN_CTRL:  rd_word = main_ctrl_q;
      OFF_EXT_CTRL:   rd_word = ext_control_q;
      OFF_INV_WAYS:   rd_word = inv_ways_q;
      OFF_CLN_WAYS:   rd_word = cln_ways_q;
      OFF_FLS_WAYS:   rd_word = fls_ways_q;
      OFF_DATA_LOCK:  rd_word = data_way_lock_q;
      OFF_INSTR_LOCK: rd_word = instr_way_lock_q;
      OFF_LINE_TAG:   rd_word = line_tag_q;
      OFF_DBG_CTRL:   rd_word = dbg_ctrl_q;
      default:        rd_word = 32'h0000_0000;
    endcase
  end

  // identification and geometry have no write path at all
  // nothing here watches other caches or bus traffic

  logic        rd_take;
  logic [63:0] rd_q;
  logic        rd_line_q;

  assign rd_take = rw_start && !rw_hwrite && size_ok(rw_addr_now, rw_hsize);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_q      <= 64'h0000_0000_0000_0000;
      rd_line_q <= 1'b0;
    end else if (rw_hready) begin
      rd_q      <= rd_take ? {rd_word, rd_word} : 64'h0000_0000_0000_0000;
      rd_line_q <= rd_take && is_line(rw_addr_now);
    end
  end

  // replicated word suits either lane; line data uses its own lanes
  assign rw_hrdata = rd_line_q ? line_rd_q : rd_q;

endmodule : ccr_regs

// >>> hdl/ccr_pkg.sv
// constants, offsets and helpers for the cache controller register bank
// Functional notes
// - read-write port writes only with its select high and steer low
// - write-only port writes only with its select high and steer high
// - read data leaves only on the read-write port, select high
// - register chosen by address bits eleven down to two
// - all registers sit at fixed offsets in a relocatable 4KB window
// - word transfers only; 64-bit access to ordinary registers is unpredictable
// - line data words also accept 64-bit transfers
// - reads of unmapped offsets return zero
// - reset clears all bits unless a register defines another value
// - registers read back what was written unless stated otherwise
// - writes to the identification and geometry words are ignored
// - identification value includes the layout identifier pins
// - no coherency protocol and no snooping
// - control bit zero clear bypasses the cache, set enables it
// - enable change seen by a port only at its next transaction
package ccr_pkg;

  localparam logic [11:0] OFF_IDENT      = 12'h000;
  localparam logic [11:0] OFF_GEOMETRY   = 12'h004;
  localparam logic [11:0] OFF_MAIN_CTRL  = 12'h100;
  localparam logic [11:0] OFF_EXT_CTRL   = 12'h104;
  localparam logic [11:0] OFF_SYNC_OP    = 12'h730;
  localparam logic [11:0] OFF_INV_PHYS   = 12'h770;
  localparam logic [11:0] OFF_INV_WAYS   = 12'h77c;
  localparam logic [11:0] OFF_CLN_PHYS   = 12'h7b0;
  localparam logic [11:0] OFF_CLN_SETWAY = 12'h7b8;
  localparam logic [11:0] OFF_CLN_WAYS   = 12'h7bc;
  localparam logic [11:0] OFF_FLS_PHYS   = 12'h7f0;
  localparam logic [11:0] OFF_FLS_SETWAY = 12'h7f8;
  localparam logic [11:0] OFF_FLS_WAYS   = 12'h7fc;
  localparam logic [11:0] OFF_DATA_LOCK  = 12'h900;
  localparam logic [11:0] OFF_INSTR_LOCK = 12'h904;
  localparam logic [11:0] OFF_TEST_OP    = 12'hf00;
  localparam logic [11:0] OFF_LINE_FIRST = 12'hf10;
  localparam logic [11:0] OFF_LINE_LAST  = 12'hf2c;
  localparam logic [11:0] OFF_LINE_TAG   = 12'hf30;
  localparam logic [11:0] OFF_DBG_CTRL   = 12'hf40;

  localparam logic [31:0] RST_MAIN_CTRL  = 32'h0000_0000;
  localparam logic [31:0] RST_EXT_CTRL   = 32'h0002_0fff;
  localparam logic [31:0] RST_ZERO       = 32'h0000_0000;

  // writable bits: control has only the enable, extended control bits 24..0
  localparam logic [31:0] MASK_MAIN_CTRL = 32'h0000_0001;
  localparam logic [31:0] MASK_EXT_CTRL  = 32'h01ff_ffff;
  localparam int          POS_ENABLE     = 0;

  // identification layout
  localparam int POS_ID_IMPL = 24;
  localparam int POS_ID_PINS = 10;
  localparam int POS_ID_PART = 6;
  localparam int POS_ID_REL  = 0;

  // geometry layout, sizes pulled from extended control
  localparam logic [3:0] GEO_CTYPE     = 4'he;
  localparam int         POS_GEO_CTYPE = 25;
  localparam int         POS_GEO_DWAY  = 20;
  localparam int         POS_GEO_DASC  = 15;
  localparam int         POS_GEO_IWAY  = 8;
  localparam int         POS_GEO_IASC  = 3;
  localparam int         POS_AUX_WAY   = 17;
  localparam int         POS_AUX_ASC   = 13;

  localparam logic [2:0] HSIZE_WORD  = 3'h2;
  localparam logic [2:0] HSIZE_DWORD = 3'h3;
  localparam logic [1:0] HRESP_OKAY  = 2'h0;

  function automatic logic is_line(input logic [11:0] a);
    is_line = (a >= OFF_LINE_FIRST) && (a <= OFF_LINE_LAST);
  endfunction : is_line

  // word transfers everywhere, doublewords only on aligned line data
  function automatic logic size_ok(input logic [11:0] a, input logic [2:0] s);
    size_ok = (s == HSIZE_WORD) || ((s == HSIZE_DWORD) && is_line(a) && !a[2]);
  endfunction : size_ok

  function automatic logic [31:0] geometry(input logic [31:0] aux);
    logic [31:0] g;
    g = 32'h0000_0000;
    g[POS_GEO_CTYPE +: 4] = GEO_CTYPE;
    g[POS_GEO_DWAY  +: 3] = aux[POS_AUX_WAY +: 3];
    g[POS_GEO_DASC  +: 4] = aux[POS_AUX_ASC +: 4];
    g[POS_GEO_IWAY  +: 3] = aux[POS_AUX_WAY +: 3];
    g[POS_GEO_IASC  +: 4] = aux[POS_AUX_ASC +: 4];
    geometry = g;
  endfunction : geometry

endpackage : ccr_pkg

// >>> hdl/ccr_port_capture.sv
// address phase capture for one slave port
`timescale 1ns/1ps
module ccr_port_capture
  import ccr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        select,
  input  wire logic        allow,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [11:0] haddr,
  input  wire logic        hready,
  output logic             start,
  output logic             act_q,
  output logic             write_q,
  output logic [11:0]      addr_q
);

  // nonseq or seq with the previous beat finished
  assign start = select && htrans[1] && hready;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      act_q   <= 1'b0;
      write_q <= 1'b0;
      addr_q  <= 12'h000;
    end else if (hready) begin
      act_q   <= start && allow && size_ok(haddr, hsize);
      write_q <= hwrite;
      addr_q  <= {haddr[11:2], 2'h0};
    end
  end

endmodule : ccr_port_capture

// >>> hdl/ccr_line_mem.sv
// debug line data store, registered read
`timescale 1ns/1ps
module ccr_line_mem #(
  parameter int WORD  = 32,
  parameter int DEPTH = 4
) (
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic [$clog2(DEPTH)-1:0] wr_index,
  input  wire logic [1:0]               wr_lane,
  input  wire logic [2*WORD-1:0]        wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_index,
  output logic      [2*WORD-1:0]        rd_data_q
);

  logic [2*WORD-1:0] mem_q [DEPTH];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      if (wr_lane[0]) begin
        mem_q[wr_index][WORD-1:0] <= wr_data[WORD-1:0];
      end
      if (wr_lane[1]) begin
        mem_q[wr_index][2*WORD-1:WORD] <= wr_data[2*WORD-1:WORD];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= mem_q[rd_index];
    end
  end

endmodule : ccr_line_mem

// >>> sim/ccr_regs_asserts.sv
// port checker for the cache controller register bank
`timescale 1ns/1ps
module ccr_regs_asserts
  import ccr_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        rw_port_reg_select,
  input wire logic [1:0]  rw_htrans,
  input wire logic        rw_hwrite,
  input wire logic [2:0]  rw_hsize,
  input wire logic [11:0] rw_slave_port_address,
  input wire logic        rw_hready,
  input wire logic        rw_hreadyout,
  input wire logic [1:0]  rw_hresp,
  input wire logic [63:0] rw_hrdata,
  input wire logic        wo_port_reg_select,
  input wire logic [1:0]  wo_htrans,
  input wire logic        wo_hwrite,
  input wire logic [2:0]  wo_hsize,
  input wire logic [11:0] wo_slave_port_address,
  input wire logic [63:0] wo_hwdata,
  input wire logic        wo_hready,
  input wire logic        wo_hreadyout,
  input wire logic        write_port_steer,
  input wire logic [5:0]  layout_identifier_pins,
  input wire logic        rw_txn_start,
  input wire logic        wo_txn_start,
  input wire logic        rw_cache_enable_q,
  input wire logic        wo_cache_enable_q,
  input wire logic [31:0] ext_control_q,
  input wire logic [31:0] data_way_lock_q,
  input wire logic        maint_valid_q,
  input wire logic [11:0] maint_offset_q,
  input wire logic [31:0] maint_data_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic rw_go;
  logic wo_go;
  // word address phases only; doublewords never reach maintenance offsets
  assign rw_go = rw_port_reg_select & rw_htrans[1] & rw_hready & (rw_hsize == HSIZE_WORD);
  assign wo_go = wo_port_reg_select & wo_htrans[1] & wo_hready & (wo_hsize == HSIZE_WORD);

  okay_resp_a: assert property (rw_hreadyout && wo_hreadyout && rw_hresp == HRESP_OKAY)
    else $error("slave port not ready or not okay");
  reset_values_a: assert property ($rose(rst_n) |-> ext_control_q == RST_EXT_CTRL
    && data_way_lock_q == RST_ZERO && !rw_cache_enable_q && !wo_cache_enable_q && !maint_valid_q)
    else $error("register not at reset value");
  rw_enable_hold_a: assert property (!rw_txn_start |=> $stable(rw_cache_enable_q))
    else $error("rw enable moved without transaction start");
  wo_enable_hold_a: assert property (!wo_txn_start |=> $stable(wo_cache_enable_q))
    else $error("wo enable moved without transaction start");
  wo_write_a: assert property (wo_go && wo_hwrite && write_port_steer && !rw_go
    && wo_slave_port_address == OFF_SYNC_OP |-> ##2 maint_valid_q && maint_offset_q == OFF_SYNC_OP
    && maint_data_q == $past(wo_hwdata[31:0])) else $error("steered wo write not taken");
  wo_steer_off_a: assert property (wo_go && wo_hwrite && !write_port_steer && !rw_go |-> ##2 !maint_valid_q)
    else $error("wo write taken while not steered");
  rw_steer_off_a: assert property (rw_go && rw_hwrite && write_port_steer && !wo_go |-> ##2 !maint_valid_q)
    else $error("rw write taken while steered away");
  unmapped_zero_a: assert property (rw_go && !rw_hwrite && rw_slave_port_address == 12'h108
    |=> rw_hrdata == 64'h0) else $error("unmapped read not zero");
  ident_pins_a: assert property (rw_go && !rw_hwrite && rw_slave_port_address == OFF_IDENT && $past(rst_n, 3)
    |=> rw_hrdata[23:10] == {8'h00, layout_identifier_pins}) else $error("identifier pins not in ident");
endmodule : ccr_regs_asserts

bind ccr_regs ccr_regs_asserts u_ccr_regs_asserts (.*);

// >>> sim/ccr_ahb_master.sv
// bus master model driving one slave port of the register bank
`timescale 1ns/1ps
module ccr_ahb_master (
  input  wire logic        clock,
  input  wire logic        hreadyout,
  input  wire logic [63:0] hrdata,
  output logic             sel,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [11:0]      haddr,
  output logic [63:0]      hwdata
);
  initial begin
    sel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 12'h0;
    hwdata = 64'h0;
  end

  // caller passes word size, or doubleword on line data only
  task automatic xfer(input logic w, input logic [11:0] a, input logic [2:0] s, input logic [63:0] d,
                      output logic [63:0] r, output logic ok);
    int n;
    @(posedge clock);
    sel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= s;
    haddr <= a;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    ok = (n < 16);
    // released address shows its inverse, not a stale copy
    sel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~a;
    hwdata <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    ok = ok && (n < 16);
    r = hrdata;
    hwdata <= ~d;
  endtask : xfer
endmodule : ccr_ahb_master

// >>> sim/ccr_regs_bench.sv
// self-checking bench for the cache controller register bank
`timescale 1ns/1ps
module ccr_regs_bench;
  import ccr_pkg::*;
  localparam logic [7:0]  IMPL  = 8'h3c; // arbitrary value
  localparam logic [5:0]  PINS  = 6'h2d;
  localparam logic [31:0] IDENT = {IMPL, 8'h00, PINS, 4'h1, 6'h0f};
  logic        clock, rst_n, steer, rw_start, wo_start, rw_en, wo_en, m_vld;
  logic        rw_sel, rw_wr, rw_rdy, wo_sel, wo_wr, wo_rdy;
  logic [1:0]  rw_tr, wo_tr, rw_resp, wo_resp;
  logic [2:0]  rw_sz, wo_sz;
  logic [11:0] rw_a, wo_a, m_off;
  logic [63:0] rw_wd, wo_wd, rw_rd;
  logic [31:0] ext_q, dlock_q, ilock_q, m_data;
  int          error_cnt, total_checks;

  ccr_regs #(.ID_IMPLEMENTOR(IMPL), .ID_PART(4'h1), .ID_RELEASE(6'h0f)) u_ccr_regs (
    .clock(clock), .rst_n(rst_n), .rw_port_reg_select(rw_sel), .rw_htrans(rw_tr), .rw_hwrite(rw_wr),
    .rw_hsize(rw_sz), .rw_slave_port_address(rw_a), .rw_hwdata(rw_wd), .rw_hready(rw_rdy),
    .rw_hreadyout(rw_rdy), .rw_hresp(rw_resp), .rw_hrdata(rw_rd), .wo_port_reg_select(wo_sel),
    .wo_htrans(wo_tr), .wo_hwrite(wo_wr), .wo_hsize(wo_sz), .wo_slave_port_address(wo_a),
    .wo_hwdata(wo_wd), .wo_hready(wo_rdy), .wo_hreadyout(wo_rdy), .wo_hresp(wo_resp),
    .write_port_steer(steer), .layout_identifier_pins(PINS), .rw_txn_start(rw_start),
    .wo_txn_start(wo_start), .rw_cache_enable_q(rw_en), .wo_cache_enable_q(wo_en),
    .ext_control_q(ext_q), .data_way_lock_q(dlock_q), .instr_way_lock_q(ilock_q),
    .maint_valid_q(m_vld), .maint_offset_q(m_off), .maint_data_q(m_data));
  ccr_ahb_master u_rw_master (.clock(clock), .hreadyout(rw_rdy), .hrdata(rw_rd), .sel(rw_sel),
    .htrans(rw_tr), .hwrite(rw_wr), .hsize(rw_sz), .haddr(rw_a), .hwdata(rw_wd));
  ccr_ahb_master u_wo_master (.clock(clock), .hreadyout(wo_rdy), .hrdata(64'h0), .sel(wo_sel),
    .htrans(wo_tr), .hwrite(wo_wr), .hsize(wo_sz), .haddr(wo_a), .hwdata(wo_wd));

  always #50 clock = ~clock;

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // port select: 0 read-write port, 1 write-only port; a hang ends the run
  task automatic bus(input bit p, input logic w, input logic [11:0] a, input logic [2:0] s,
                     input logic [63:0] d, output logic [63:0] r);
    logic ok;
    if (p) u_wo_master.xfer(w, a, s, d, r, ok);
    else u_rw_master.xfer(w, a, s, d, r, ok);
    // let the data phase edge settle before anyone looks at registers
    @(negedge clock);
    if (!ok) begin
      error_cnt++;
      $display("BAD %0t bus hang", $time);
      complete_run();
    end
  endtask : bus

  task automatic t_reset_regs();
    logic [11:0] a[8] = '{OFF_IDENT, OFF_GEOMETRY, OFF_MAIN_CTRL, OFF_EXT_CTRL, OFF_INV_WAYS, OFF_FLS_WAYS,
                          OFF_DATA_LOCK, OFF_DBG_CTRL};
    logic [31:0] e[8] = '{IDENT, 32'h1c10_0100, 32'h0, 32'h0002_0fff, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [63:0] r;
    for (int i = 0; i < 8; i++) begin
      bus(0, 0, a[i], HSIZE_WORD, 64'h0, r);
      chk(r, {e[i], e[i]});
    end
    $display("done reset values");
  endtask : t_reset_regs

  task automatic t_rw_regs();
    logic [63:0] r;
    bus(0, 1, OFF_MAIN_CTRL, HSIZE_WORD, {2{32'h1}}, r); // reserved bits written as zero
    bus(0, 0, OFF_MAIN_CTRL, HSIZE_WORD, 64'h0, r);
    chk(r, {2{32'h1}});
    bus(0, 1, OFF_MAIN_CTRL, HSIZE_WORD, 64'h0, r); // cache off before the next step
    bus(0, 1, OFF_IDENT, HSIZE_WORD, 64'h0, r);
    bus(0, 0, OFF_IDENT, HSIZE_WORD, 64'h0, r);
    chk(r, {2{IDENT}});
    bus(0, 0, OFF_EXT_CTRL, HSIZE_WORD, 64'h0, r);
    r[19:17] = 3'h7; // read-modify-write with cache off
    bus(0, 1, OFF_EXT_CTRL, HSIZE_WORD, {2{r[31:0]}}, r);
    chk({32'h0, ext_q}, 64'h0002_0fff | 64'h000e_0000);
    bus(0, 0, OFF_GEOMETRY, HSIZE_WORD, 64'h0, r);
    chk(r, {2{32'h1c70_0700}});
    bus(0, 1, OFF_DATA_LOCK, HSIZE_WORD, {2{32'h0000_00a5}}, r);
    bus(0, 0, OFF_DATA_LOCK, HSIZE_WORD, 64'h0, r);
    chk(r, {2{32'h0000_00a5}});
    $display("done read write");
  endtask : t_rw_regs

  task automatic t_steer();
    logic [63:0] r;
    @(posedge clock);
    steer <= 1'b1;
    bus(0, 1, OFF_INSTR_LOCK, HSIZE_WORD, {2{32'h11}}, r);
    chk({32'h0, ilock_q}, 64'h0);
    bus(0, 1, OFF_SYNC_OP, HSIZE_WORD, {2{32'h55}}, r);
    chk({63'h0, m_vld}, 64'h0);
    bus(1, 1, OFF_INSTR_LOCK, HSIZE_WORD, {2{32'h22}}, r);
    bus(0, 0, OFF_INSTR_LOCK, HSIZE_WORD, 64'h0, r);
    chk(r, {2{32'h22}});
    bus(1, 1, OFF_SYNC_OP, HSIZE_WORD, {2{32'hbeef_0001}}, r);
    chk({m_vld, m_off, m_data}, {1'b1, OFF_SYNC_OP, 32'hbeef_0001});
    @(negedge clock);
    chk({63'h0, m_vld}, 64'h0);
    @(posedge clock);
    steer <= 1'b0;
    bus(1, 1, OFF_INSTR_LOCK, HSIZE_WORD, {2{32'h33}}, r);
    chk({32'h0, ilock_q}, 64'h22);
    bus(1, 1, OFF_SYNC_OP, HSIZE_WORD, {2{32'h66}}, r);
    chk({63'h0, m_vld}, 64'h0);
    bus(0, 1, OFF_INSTR_LOCK, HSIZE_WORD, {2{32'h44}}, r);
    chk({32'h0, ilock_q}, 64'h44);
    $display("done steering");
  endtask : t_steer

  task automatic t_unmapped();
    logic [11:0] a[4] = '{12'h008, 12'h108, OFF_SYNC_OP, OFF_TEST_OP}; // unmapped offsets plus the write-only sync and test words
    logic [63:0] r;
    for (int i = 0; i < 4; i++) begin
      bus(0, 0, a[i], HSIZE_WORD, 64'h0, r);
      chk(r, 64'h0);
    end
    $display("done unmapped");
  endtask : t_unmapped

  task automatic t_line();
    logic [63:0] r;
    bus(0, 1, OFF_LINE_FIRST, HSIZE_DWORD, 64'h0123_4567_89ab_cdef, r); // bench only
    bus(0, 0, OFF_LINE_FIRST, HSIZE_DWORD, 64'h0, r);
    chk(r, 64'h0123_4567_89ab_cdef);
    bus(0, 1, OFF_LINE_FIRST + 12'h4, HSIZE_WORD, {2{32'h0000_00a5}}, r);
    bus(0, 0, OFF_LINE_FIRST, HSIZE_DWORD, 64'h0, r);
    chk(r, 64'h0000_00a5_89ab_cdef);
    $display("done line data");
  endtask : t_line

  task automatic pulse(input bit p);
    @(posedge clock);
    if (p) wo_start <= 1'b1;
    else rw_start <= 1'b1;
    @(posedge clock);
    wo_start <= 1'b0;
    rw_start <= 1'b0;
    @(negedge clock);
  endtask : pulse

  task automatic t_enable();
    logic [63:0] r;
    bus(0, 1, OFF_MAIN_CTRL, HSIZE_WORD, {2{32'h0}}, r);
    pulse(0);
    pulse(1);
    bus(0, 1, OFF_MAIN_CTRL, HSIZE_WORD, {2{32'h1}}, r);
    @(negedge clock);
    chk({rw_en, wo_en}, 2'b00);
    pulse(0);
    chk({rw_en, wo_en}, 2'b10);
    pulse(1);
    chk({rw_en, wo_en}, 2'b11);
    $display("done enable");
  endtask : t_enable

  task automatic t_reset_again();
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    chk({rw_en, wo_en, ext_q, dlock_q}, {2'b00, 32'h0002_0fff, 32'h0});
    $display("done second reset");
  endtask : t_reset_again

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    steer = 1'b0;
    rw_start = 1'b0;
    wo_start = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset_regs();
    t_rw_regs();
    t_steer();
    t_unmapped();
    t_line();
    t_enable();
    t_reset_again();
    complete_run();
  end
endmodule : ccr_regs_bench
